// ### rtl/scser_top.sv
/*
 Per-socket configuration extension registers and socket event registers:
 dma slave setup, legacy socket number and index/data pair, chip controls,
 power state, and the socket status registers in memory space.
 Assumes host strobes are one-cycle and synchronous to clk; read data
 appears one cycle after the read strobe.
*/
`timescale 1ns/1ps
module scser_top
   import scser_pkg::*;
#(
   parameter logic [3:0] SOCK_VOLTS = SOCK_VOLTS_RST // socket voltages available
) (
   input wire logic clk, // pci clock, 100 MHz
   input wire logic reset, // pci reset, active high
   input wire logic seg_reset, // software bus segment reset
   input wire logic is_function0, // this socket is function 0
   input wire logic cfg_wr, // config write strobe
   input wire logic cfg_rd, // config read strobe
   input wire logic [7:0] cfg_addr, // config byte offset
   input wire logic [31:0] cfg_wdata, // config write data
   output logic [31:0] cfg_rdata, // config read data
   input wire logic mem_wr, // memory write strobe
   input wire logic mem_rd, // memory read strobe
   input wire logic [11:0] mem_addr, // offset from memory base
   input wire logic [31:0] mem_wdata, // memory write data
   output logic [31:0] mem_rdata, // memory read data
   input wire logic io_wr, // legacy io write strobe
   input wire logic io_rd, // legacy io read strobe
   input wire logic [15:0] io_addr, // legacy io address
   input wire logic [7:0] io_wdata, // legacy io write data
   output logic [7:0] io_rdata, // legacy io read data
   output logic io_hit, // io access claimed by this socket pair
   output logic legacy_wr, // write pulse to indexed register
   output logic legacy_rd, // read pulse to indexed register
   output logic [5:0] legacy_index, // index within socket group
   output logic [7:0] legacy_wdata, // indexed write data
   input wire logic [7:0] legacy_rdata, // indexed register read data
   input wire logic card_status_change, // card status change or wake
   input wire logic card_detect_first, // first card detect
   input wire logic card_detect_second, // second card detect
   input wire logic powerup_start, // pulse, power-up sequence begins
   input wire logic power_cycle_done, // pulse, power sequence done
   input wire logic card_powered, // socket supply is on
   input wire logic cardbus_card, // inserted card is cardbus
   input wire logic vcc_req, // pulse, software supply request
   input wire logic [2:0] vcc_code, // 0 off, 1..4 voltage choice
   input wire logic [3:0] voltage_sense_and_detect_lines, // decoded supported voltages
   output logic [3:0] vcc_apply, // one-hot supply enables
   input wire logic [1:0] dma_request_enable, // request enables from ext control
   output logic dma_allowed, // dma channel may run
   output logic dma_16bit, // 16-bit transfers at the socket
   output logic dma_ext_addr, // extended addressing enabled
   output logic [27:0] dma_io_base, // dma register io base
   input wire logic pci_int_mode, // pci style interrupt signalling
   output logic mgmt_int_pci, // management interrupt on pci pin
   output logic mgmt_int_isa, // management interrupt on isa line
   output logic [31:0] subsys_id, // subsystem vendor and device id
   output logic serial_int_pins, // pci pins in serial stream
   output logic pin_map_write_lock, // pin mapping writes blocked
   output logic master_prefetch_disable, // master prefetch blocked
   output logic card_reset_req // drive card reset
);
   import scser_pkg::*;

   typedef struct packed {
      logic [31:0] subsys;
      logic [31:0] dma;
      logic [2:0] socknum;
      logic [10:0] misc;
      logic [1:0] pstate;
      logic wake_event_enable;
      logic [3:0] mask;
      logic [7:0] ctrl;
      logic [7:0] io_index;
      logic [3:0] vcc;
      logic bad_vcc;
      logic [31:0] cfg_rdata;
      logic [31:0] mem_rdata;
      logic [7:0] io_rdata;
   } scser_main_s;

   scser_main_s st_q, next_st;
   scser_evt_if evt_if ();
   logic retain;
   logic [10:0] misc_wm;
   logic [15:0] pair_base;
   logic index_ours;
   logic [31:0] present;
   logic [1:0] vsel;
   logic mgmt_int;

   scser_event u_event (
      .clk(clk),
      .reset(reset),
      .card_status_change(card_status_change),
      .card_detect_first(card_detect_first),
      .card_detect_second(card_detect_second),
      .powerup_start(powerup_start),
      .power_cycle_done(power_cycle_done),
      .e(evt_if)
   );

   // wake context survives only a segment reset leaving d3 with wake enabled
   assign retain = st_q.wake_event_enable && st_q.pstate == PS_D3;
   assign misc_wm = is_function0 ? MISC_WMASK_F0 : MISC_WMASK_FN;
   assign pair_base = st_q.socknum[2] ? LEGACY_IO_ALT : LEGACY_IO_BASE;
   assign io_hit = (io_wr || io_rd) && io_addr[15:1] == pair_base[15:1];
   assign index_ours = st_q.io_index[7:6] == st_q.socknum[1:0];
   assign vsel = 2'(vcc_code - 3'h1);
   assign present = {SOCK_VOLTS, 18'h0, st_q.bad_vcc, 3'h0, cardbus_card, 1'b0,
      card_powered, card_detect_second, card_detect_first, card_status_change};

   assign evt_if.mask = st_q.mask;
   assign evt_if.force_stb = mem_wr && mem_addr == OFF_FORCE;
   assign evt_if.force_bits = mem_wdata[3:0];
   assign evt_if.clr_stb = mem_wr && mem_addr == OFF_EVENT;
   assign evt_if.clr_bits = mem_wdata[3:0];
   assign evt_if.ctx_clear = seg_reset && !retain;

   always_comb begin
      next_st = st_q;
      if (cfg_wr) begin
         case (cfg_addr)
            CFG_SUBSYS: begin
               if (!st_q.misc[MISC_LOCK]) begin
                  next_st.subsys = cfg_wdata;
               end
            end
            CFG_PM_CSR: begin
               next_st.pstate = cfg_wdata[1:0];
               next_st.wake_event_enable = cfg_wdata[PM_WAKE_EVENT_ENABLE];
            end
            CFG_DMA: next_st.dma = cfg_wdata;
            CFG_SOCKNUM: next_st.socknum = cfg_wdata[2:0];
            CFG_MISC: begin
               next_st.misc = (st_q.misc & ~misc_wm) | (cfg_wdata[10:0] & misc_wm);
            end
            default: begin
            end
         endcase
      end
      if (cfg_rd) begin
         case (cfg_addr)
            CFG_SUBSYS: next_st.cfg_rdata = st_q.subsys;
            CFG_PM_CSR: next_st.cfg_rdata = {23'h0, st_q.wake_event_enable, 6'h0, st_q.pstate};
            CFG_DMA: next_st.cfg_rdata = st_q.dma;
            CFG_SOCKNUM: next_st.cfg_rdata = {29'h0, st_q.socknum};
            CFG_MISC: next_st.cfg_rdata = {21'h0, st_q.misc};
            default: next_st.cfg_rdata = '0;
         endcase
      end
      if (mem_wr) begin
         case (mem_addr)
            OFF_MASK: next_st.mask = mem_wdata[3:0];
            OFF_CONTROL: next_st.ctrl = mem_wdata[7:0] & CTRL_WMASK;
            default: begin
            end
         endcase
      end
      if (mem_rd) begin
         case (mem_addr)
            OFF_EVENT: next_st.mem_rdata = {28'h0, evt_if.events};
            OFF_MASK: next_st.mem_rdata = {28'h0, st_q.mask};
            OFF_PRESENT: next_st.mem_rdata = present;
            OFF_CONTROL: next_st.mem_rdata = {24'h0, st_q.ctrl};
            default: next_st.mem_rdata = '0; // force reads zero
         endcase
      end
      if (io_hit && io_wr && !io_addr[0]) begin
         next_st.io_index = io_wdata;
      end
      if (io_hit && io_rd) begin
         if (!io_addr[0]) begin
            next_st.io_rdata = st_q.io_index;
         end else begin
            next_st.io_rdata = index_ours ? legacy_rdata : 8'h00;
         end
      end
      if (vcc_req) begin
         if (vcc_code == 3'h0) begin
            next_st.vcc = '0;
         end else if (vcc_code > 3'h4
            || (cardbus_card && !voltage_sense_and_detect_lines[vsel])) begin
            next_st.bad_vcc = 1'b1;
         end else begin
            next_st.vcc = 4'h1 << vsel;
         end
      end
      if (seg_reset) begin
         next_st.pstate = PS_D0;
         next_st.subsys = '0;
         next_st.dma = '0;
         next_st.socknum = '0;
         next_st.misc[9:0] = '0;
         next_st.io_index = '0;
         next_st.vcc = '0;
         next_st.bad_vcc = 1'b0;
         if (!retain) begin
            next_st.mask = '0;
            next_st.ctrl = '0;
            next_st.misc[MISC_D3NORST] = 1'b0;
            next_st.wake_event_enable = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= next_st;
      end
   end

   assign cfg_rdata = st_q.cfg_rdata;
   assign mem_rdata = st_q.mem_rdata;
   assign io_rdata = st_q.io_rdata;
   assign legacy_wr = io_hit && io_wr && io_addr[0] && index_ours;
   assign legacy_rd = io_hit && io_rd && io_addr[0] && index_ours;
   assign legacy_index = st_q.io_index[5:0];
   assign legacy_wdata = io_wdata;
   assign vcc_apply = st_q.vcc;
   assign dma_allowed = st_q.dma[DMA_CHAN_EN] && |dma_request_enable;
   assign dma_16bit = |st_q.dma[2:1];
   assign dma_ext_addr = st_q.dma[DMA_EXT];
   assign dma_io_base = st_q.dma[31:4];
   // interrupt comes from the latched events, never the live inputs
   assign mgmt_int = evt_if.event_int;
   assign mgmt_int_pci = mgmt_int && (pci_int_mode || !st_q.misc[MISC_MGMT]);
   assign mgmt_int_isa = mgmt_int && !pci_int_mode && st_q.misc[MISC_MGMT];
   assign subsys_id = st_q.subsys;
   assign serial_int_pins = st_q.misc[MISC_SERIAL];
   assign pin_map_write_lock = st_q.misc[MISC_PINLOCK];
   assign master_prefetch_disable = st_q.misc[MISC_NOPREF];
   assign card_reset_req = st_q.pstate == PS_D3 && card_powered
      && !st_q.misc[MISC_D3NORST];

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_enter_d3;
      cfg_wr && cfg_addr == CFG_PM_CSR && cfg_wdata[1:0] == PS_D3 && !seg_reset;
   endsequence

   chk_dma_gate: assert property (cfg_wr && cfg_addr == CFG_DMA && !cfg_wdata[0]
      && !seg_reset |=> !dma_allowed)
      else $error("dma allowed with channel disabled");
   chk_dma_size: assert property (cfg_wr && cfg_addr == CFG_DMA && cfg_wdata[2:1] == 2'h2
      && !seg_reset |=> dma_16bit)
      else $error("transfer size decode wrong");
   chk_id_lock: assert property (st_q.misc[MISC_LOCK] && cfg_wr && cfg_addr == CFG_SUBSYS
      && !seg_reset |=> $stable(subsys_id))
      else $error("locked subsystem id was written");
   chk_pin_lock: assert property (!is_function0 && cfg_wr && cfg_addr == CFG_MISC
      && !seg_reset |=> $stable(pin_map_write_lock) && $stable(master_prefetch_disable))
      else $error("chip bit written outside function 0");
   chk_d3_reset: assert property (s_enter_d3 ##0 !st_q.misc[MISC_D3NORST]
      ##1 card_powered |-> card_reset_req)
      else $error("no card reset in d3");
   chk_vcc_refuse: assert property (vcc_req && cardbus_card && vcc_code inside {[1:4]}
      && !voltage_sense_and_detect_lines[vsel] && !seg_reset
      |=> $stable(vcc_apply) && st_q.bad_vcc)
      else $error("unsupported voltage applied");
   chk_legacy_pair: assert property (io_wr && io_addr == LEGACY_IO_ALT && st_q.socknum[2]
      |-> io_hit)
      else $error("alternate pair not claimed");
   chk_ctx_keep: assert property (seg_reset && retain && !mem_wr |=> $stable(st_q.mask)
      && st_q.pstate == PS_D0)
      else $error("wake context lost on segment reset");
   chk_mgmt_route: assert property (mgmt_int && !pci_int_mode && st_q.misc[MISC_MGMT]
      |-> mgmt_int_isa && !mgmt_int_pci)
      else $error("management interrupt misrouted");
endmodule

// ### rtl/scser_pkg.sv
/*
 Constants for the socket configuration and status event register block:
 configuration offsets, socket register offsets, field positions, write masks
 and reset values. Assumes one PCI clock and the synchronous PCI reset.
*/
package scser_pkg;
   localparam logic [7:0] CFG_SUBSYS = 8'h40;
   localparam logic [7:0] CFG_PM_CSR = 8'h84;
   localparam logic [7:0] CFG_DMA = 8'h90;
   localparam logic [7:0] CFG_SOCKNUM = 8'h94;
   localparam logic [7:0] CFG_MISC = 8'h98;
   localparam logic [11:0] OFF_EVENT = 12'h000;
   localparam logic [11:0] OFF_MASK = 12'h004;
   localparam logic [11:0] OFF_PRESENT = 12'h008;
   localparam logic [11:0] OFF_FORCE = 12'h00C;
   localparam logic [11:0] OFF_CONTROL = 12'h010;
   localparam int EV_CSC = 0;
   localparam int EV_CD1 = 1;
   localparam int EV_CD2 = 2;
   localparam int EV_PWR = 3;
   localparam int DMA_CHAN_EN = 0;
   localparam int DMA_EXT = 3;
   localparam int PM_WAKE_EVENT_ENABLE = 8;
   localparam int MISC_LOCK = 0;
   localparam int MISC_MGMT = 1;
   localparam int MISC_SERIAL = 2;
   localparam int MISC_PINLOCK = 8;
   localparam int MISC_NOPREF = 9;
   localparam int MISC_D3NORST = 10;
   localparam logic [10:0] MISC_WMASK_F0 = 11'h707;
   localparam logic [10:0] MISC_WMASK_FN = 11'h407;
   localparam logic [7:0] CTRL_WMASK = 8'hFF;
   localparam logic [1:0] PS_D0 = 2'h0;
   localparam logic [1:0] PS_D3 = 2'h3;
   localparam logic [15:0] LEGACY_IO_BASE = 16'h03E0;
   localparam logic [15:0] LEGACY_IO_ALT = 16'h03E2;
   localparam logic [1:0] CD_PREV_RST = 2'h3;
   localparam logic [3:0] SOCK_VOLTS_RST = 4'h3;
endpackage

// ### rtl/scser_evt_if.sv
/*
 Carrier between the register block and its event latch: mask, force and
 clear strobes one way, latched events and the gated interrupt the other.
 Assumes both ends run on the same PCI clock.
*/
`timescale 1ns/1ps
interface scser_evt_if;
   logic [3:0] mask;
   logic force_stb;
   logic [3:0] force_bits;
   logic clr_stb;
   logic [3:0] clr_bits;
   logic ctx_clear;
   logic [3:0] events;
   logic event_int;
   modport regs (output mask, force_stb, force_bits, clr_stb, clr_bits, ctx_clear,
      input events, event_int);
   modport evt (input mask, force_stb, force_bits, clr_stb, clr_bits, ctx_clear,
      output events, event_int);
endinterface

// ### rtl/scser_event.sv
/*
 Socket status event latch: card status change, two card detect changes and
 power cycle completion, with write-one-to-clear, masked force and the masked
 interrupt. Assumes card inputs already synchronous to clk.
*/
`timescale 1ns/1ps
module scser_event
   import scser_pkg::*;
(
   input wire logic clk, // pci clock
   input wire logic reset, // pci reset, active high
   input wire logic card_status_change, // card status change or wake input
   input wire logic card_detect_first, // first card detect input
   input wire logic card_detect_second, // second card detect input
   input wire logic powerup_start, // pulse, socket power-up begins
   input wire logic power_cycle_done, // pulse, power-up or down complete
   scser_evt_if.evt e // link to the register block
);
   import scser_pkg::*;
   typedef enum logic {SCSER_LIVE, SCSER_BLANK} scser_phase_e;
   typedef struct packed {
      logic [3:0] ev;
      logic [1:0] cd_prev;
      logic csc_prev;
      scser_phase_e phase;
   } scser_evt_s;
   scser_evt_s st_q, next_st;
   logic [3:0] set_bits;
   logic [3:0] clr_bits;

   always_comb begin
      next_st = st_q;
      set_bits = '0;
      clr_bits = e.clr_stb ? e.clr_bits : 4'h0;
      // edge, not level: a card holding the line does not refill a cleared bit
      if (st_q.phase == SCSER_LIVE && !powerup_start) begin
         set_bits[EV_CSC] = card_status_change && !st_q.csc_prev;
      end
      set_bits[EV_CD1] = card_detect_first != st_q.cd_prev[0];
      set_bits[EV_CD2] = card_detect_second != st_q.cd_prev[1];
      set_bits[EV_PWR] = power_cycle_done;
      if (e.force_stb) begin
         set_bits = set_bits | (e.force_bits & e.mask);
      end
      next_st.ev = (st_q.ev & ~clr_bits) | set_bits; // set wins over clear
      if (e.ctx_clear) begin
         next_st.ev = '0;
      end
      next_st.cd_prev = {card_detect_second, card_detect_first};
      next_st.csc_prev = card_status_change;
      case (st_q.phase)
         SCSER_LIVE: begin
            if (powerup_start) begin
               next_st.phase = SCSER_BLANK;
            end
         end
         SCSER_BLANK: begin
            if (power_cycle_done) begin
               next_st.phase = SCSER_LIVE;
            end
         end
         default: next_st.phase = SCSER_LIVE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '{ev: 4'h0, cd_prev: CD_PREV_RST, csc_prev: 1'b0, phase: SCSER_LIVE};
      end else begin
         st_q <= next_st;
      end
   end

   assign e.events = st_q.ev;
   assign e.event_int = |(st_q.ev & e.mask);

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_done_then_rise;
      power_cycle_done && !powerup_start ##1 (!card_status_change && !powerup_start)
         ##1 (card_status_change && !powerup_start);
   endsequence
   sequence s_blanked_rise;
      (powerup_start || st_q.phase == SCSER_BLANK) && !power_cycle_done
         && !(e.force_stb && e.force_bits[EV_CSC]) && !e.events[EV_CSC];
   endsequence

   chk_csc_resume: assert property (s_done_then_rise |=> e.events[EV_CSC] || $past(e.ctx_clear))
      else $error("status change not latched after power complete");
   chk_csc_blank: assert property (s_blanked_rise |=> !e.events[EV_CSC])
      else $error("status change latched during power-up");
   chk_clear_one: assert property (e.clr_stb && e.clr_bits[EV_PWR] && !power_cycle_done
      && !e.force_stb |=> !e.events[EV_PWR])
      else $error("power cycle bit not cleared by write one");
   chk_force_mask: assert property (e.force_stb && e.force_bits[EV_PWR] && e.mask[EV_PWR]
      && !e.ctx_clear |=> e.events[EV_PWR])
      else $error("masked force did not set event");
   chk_detect_change: assert property ($changed(card_detect_first) && !e.ctx_clear
      |=> e.events[EV_CD1])
      else $error("detect change not latched");
   chk_int_gate: assert property (e.events[EV_CD2] && e.mask[EV_CD2] |-> e.event_int)
      else $error("masked event gave no interrupt");
endmodule

// ### verif/scser_socket_model.sv
/*
 Socket side of the block: answers indexed register reads and reports the
 voltages the inserted card supports. Assumes index and read pulse from the
 block are synchronous to the pci clock.
*/
`timescale 1ns/1ps
module scser_socket_model (
   input wire logic legacy_rd, // indexed read pulse
   input wire logic [5:0] legacy_index, // index within group
   output logic [7:0] legacy_rdata, // indexed read data
   output logic [3:0] voltage_sense_and_detect_lines // supported voltages
);
   // inverted outside a read so stale data can never match
   assign legacy_rdata = legacy_rd ? {2'h2, legacy_index} : ~{2'h2, legacy_index};
   assign voltage_sense_and_detect_lines = 4'h1; // 5 volt only card
endmodule

// ### verif/tb.sv
/*
 Self-checking bench for the socket register block: config, memory and
 legacy io accesses with expected values. Assumes the socket model above.
*/
`timescale 1ns/1ps
module tb;
   import scser_pkg::*;
   logic clk, reset, seg_reset, is_function0, cfg_wr, cfg_rd, mem_wr, mem_rd, io_wr, io_rd;
   logic [7:0] cfg_addr, io_wdata, io_rdata, legacy_wdata, legacy_rdata;
   logic [31:0] cfg_wdata, cfg_rdata, mem_wdata, mem_rdata, subsys_id, q;
   logic [11:0] mem_addr;
   logic [15:0] io_addr;
   logic [5:0] legacy_index;
   logic [27:0] dma_io_base;
   logic [3:0] vcc_apply, voltage_sense_and_detect_lines;
   logic [2:0] vcc_code;
   logic [1:0] dma_request_enable;
   logic io_hit, legacy_wr, legacy_rd, card_status_change, card_detect_first;
   logic card_detect_second, powerup_start, power_cycle_done, card_powered, cardbus_card;
   logic vcc_req, dma_allowed, dma_16bit, dma_ext_addr, pci_int_mode, mgmt_int_pci;
   logic mgmt_int_isa, serial_int_pins, pin_map_write_lock, master_prefetch_disable;
   logic card_reset_req;
   int failures = 0;
   int checked = 0;
   scser_top i_dut (.clk(clk), .reset(reset), .seg_reset(seg_reset), .is_function0(is_function0),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .io_wr(io_wr), .io_rd(io_rd),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
      .legacy_wr(legacy_wr), .legacy_rd(legacy_rd), .legacy_index(legacy_index),
      .legacy_wdata(legacy_wdata), .legacy_rdata(legacy_rdata),
      .card_status_change(card_status_change), .card_detect_first(card_detect_first),
      .card_detect_second(card_detect_second), .powerup_start(powerup_start),
      .power_cycle_done(power_cycle_done), .card_powered(card_powered),
      .cardbus_card(cardbus_card), .vcc_req(vcc_req), .vcc_code(vcc_code),
      .voltage_sense_and_detect_lines(voltage_sense_and_detect_lines), .vcc_apply(vcc_apply),
      .dma_request_enable(dma_request_enable), .dma_allowed(dma_allowed),
      .dma_16bit(dma_16bit), .dma_ext_addr(dma_ext_addr), .dma_io_base(dma_io_base),
      .pci_int_mode(pci_int_mode), .mgmt_int_pci(mgmt_int_pci), .mgmt_int_isa(mgmt_int_isa),
      .subsys_id(subsys_id), .serial_int_pins(serial_int_pins),
      .pin_map_write_lock(pin_map_write_lock),
      .master_prefetch_disable(master_prefetch_disable), .card_reset_req(card_reset_req));
   scser_socket_model i_sock (.legacy_rd(legacy_rd), .legacy_index(legacy_index),
      .legacy_rdata(legacy_rdata),
      .voltage_sense_and_detect_lines(voltage_sense_and_detect_lines));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // k: 0 config, 1 memory, 2 legacy io
   task automatic acc(input int k, input bit w, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      cfg_addr <= a[7:0];
      mem_addr <= a[11:0];
      io_addr <= a;
      cfg_wdata <= d;
      mem_wdata <= d;
      io_wdata <= d[7:0];
      {cfg_wr, cfg_rd} <= {k == 0 && w, k == 0 && !w};
      {mem_wr, mem_rd} <= {k == 1 && w, k == 1 && !w};
      {io_wr, io_rd} <= {k == 2 && w, k == 2 && !w};
      @(posedge clk);
      {cfg_wr, cfg_rd, mem_wr, mem_rd, io_wr, io_rd} <= 6'h0;
      #1;
      q = k == 0 ? cfg_rdata : k == 1 ? mem_rdata : {24'h0, io_rdata};
   endtask
   task automatic wr(input int k, input logic [15:0] a, input logic [31:0] d);
      acc(k, 1, a, d);
   endtask
   task automatic rd(input int k, input logic [15:0] a, input logic [31:0] e);
      acc(k, 0, a, 32'h0);
      chk(q, e);
   endtask
   // n: 0 status change, 1 power-up start, 2 power done, 3 supply request, 4 segment reset
   task automatic pulse(input int n);
      @(posedge clk);
      {seg_reset, vcc_req, power_cycle_done, powerup_start, card_status_change} <= 5'(1 << n);
      @(posedge clk);
      {seg_reset, vcc_req, power_cycle_done, powerup_start, card_status_change} <= 5'h00;
      #1;
   endtask
   task automatic pwr(input logic [2:0] c, input logic [3:0] e);
      @(posedge clk) vcc_code <= c;
      pulse(3);
      chk(32'(vcc_apply), 32'(e));
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      {seg_reset, is_function0, cfg_wr, cfg_rd, mem_wr, mem_rd, io_wr, io_rd} = 8'h0;
      {cfg_addr, cfg_wdata, mem_addr, mem_wdata, io_addr, io_wdata} = '0;
      {card_status_change, powerup_start, power_cycle_done, card_powered} = 4'h0;
      {cardbus_card, vcc_req, vcc_code, dma_request_enable, pci_int_mode} = 7'h0;
      {card_detect_first, card_detect_second, reset} = 3'h7;
      repeat (3) @(posedge clk);
      reset <= 0;
      rd(0, CFG_MISC, 32'h0);
      rd(1, OFF_EVENT, 32'h0);
      wr(0, CFG_DMA, 32'hABCDEF0A);
      rd(0, CFG_DMA, 32'hABCDEF0A);
      chk({dma_io_base, dma_ext_addr, dma_16bit, dma_allowed}, 31'h55E6F786);
      wr(0, CFG_DMA, 32'h1);
      @(posedge clk) dma_request_enable <= 2'h2;
      #1 chk({dma_16bit, dma_allowed}, 2'h1);
      $display("test dma done");
      wr(0, CFG_MISC, 32'hFFFFFFFF);
      rd(0, CFG_MISC, 32'h407);
      chk(32'(serial_int_pins), 1);
      wr(0, CFG_SUBSYS, 32'h12345678);
      rd(0, CFG_SUBSYS, 32'h0);
      @(posedge clk) is_function0 <= 1;
      wr(0, CFG_MISC, 32'h306);
      chk({pin_map_write_lock, master_prefetch_disable}, 2'h3);
      wr(0, CFG_SUBSYS, 32'h12345678);
      chk(subsys_id, 32'h12345678);
      @(posedge clk) card_powered <= 1;
      wr(0, CFG_PM_CSR, 32'h3);
      chk(32'(card_reset_req), 1);
      wr(0, CFG_MISC, 32'h706);
      chk(32'(card_reset_req), 0);
      wr(0, CFG_PM_CSR, 32'h0);
      $display("test misc done");
      wr(0, CFG_SOCKNUM, 32'hFF);
      rd(0, CFG_SOCKNUM, 32'h7);
      wr(0, CFG_SOCKNUM, 32'h5);
      wr(2, LEGACY_IO_ALT, 32'h41);
      wr(2, LEGACY_IO_BASE, 32'hC1);
      rd(2, LEGACY_IO_ALT + 16'h1, 32'h81);
      wr(2, LEGACY_IO_ALT, 32'h01);
      rd(2, LEGACY_IO_ALT + 16'h1, 32'h0);
      $display("test legacy done");
      wr(1, OFF_MASK, 32'hFFFFFFFF);
      rd(1, OFF_MASK, 32'hF);
      wr(1, OFF_FORCE, 32'hF);
      rd(1, OFF_EVENT, 32'hF);
      chk({mgmt_int_isa, mgmt_int_pci}, 2'h2);
      @(posedge clk) pci_int_mode <= 1;
      #1 chk({mgmt_int_isa, mgmt_int_pci}, 2'h1);
      @(posedge clk) pci_int_mode <= 0;
      rd(1, OFF_FORCE, 32'h0);
      wr(1, OFF_EVENT, 32'h5);
      rd(1, OFF_EVENT, 32'hA);
      wr(1, OFF_EVENT, 32'hA);
      chk(32'(mgmt_int_isa), 0);
      wr(1, OFF_MASK, 32'h0);
      wr(1, OFF_FORCE, 32'hF);
      rd(1, OFF_EVENT, 32'h0);
      @(posedge clk) card_detect_first <= 0;
      pulse(2);
      rd(1, OFF_EVENT, 32'hA);
      pulse(1);
      pulse(0);
      rd(1, OFF_EVENT, 32'hA);
      pulse(2);
      pulse(0);
      rd(1, OFF_EVENT, 32'hB);
      $display("test events done");
      @(posedge clk) cardbus_card <= 1;
      pwr(3'h2, 4'h0);
      pwr(3'h1, 4'h1);
      $display("test power done");
      wr(0, CFG_PM_CSR, 32'h103);
      wr(1, OFF_MASK, 32'h5);
      pulse(4);
      rd(1, OFF_MASK, 32'h5);
      rd(1, OFF_EVENT, 32'hB);
      rd(0, CFG_PM_CSR, 32'h100);
      chk(32'(vcc_apply), 0);
      pulse(4);
      rd(1, OFF_MASK, 32'h0);
      rd(1, OFF_EVENT, 32'h0);
      rd(0, CFG_MISC, 32'h0);
      $display("test segment reset done");
      give_verdict;
   end
   initial begin
      #200000;
      failures++;
      give_verdict;
   end
endmodule
